// file: common/latch_port_pkg.sv
// Constants shared by the serial latch load port and its lock detector
package latch_port_pkg;
    // ---------------------------------------------------------------
    // Word and latch layout
    // ---------------------------------------------------------------
    localparam int WORD_W = 24;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 2;
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_REF_DIV = 2'h1;
    localparam logic [1:0] SEL_FB_DIV = 2'h2;
    localparam logic [1:0] SEL_TEST = 2'h3;
    localparam logic [23:0] LATCH_RESET = 24'h000000;
    // Control latch fields
    localparam int PD1_BIT = 20;
    localparam int PD2_BIT = 21;
    localparam int PUMP_TRI_BIT = 11;
    localparam int MON_LSB = 5;
    localparam int MON_W = 3;
    // Reference divider latch field
    localparam int LOCK_PRECISION_BIT = 18;
    // ---------------------------------------------------------------
    // Monitor source codes
    // ---------------------------------------------------------------
    localparam logic [2:0] MON_LOW = 3'h0;
    localparam logic [2:0] MON_LOCK = 3'h1;
    localparam logic [2:0] MON_FB_DIV = 3'h2;
    localparam logic [2:0] MON_REF_DIV = 3'h4;
    // ---------------------------------------------------------------
    // Lock detect thresholds and counts
    // ---------------------------------------------------------------
    localparam int ERR_W = 8;
    localparam logic [7:0] LOCK_ERR_NS = 8'h0F;
    localparam logic [7:0] UNLOCK_ERR_NS = 8'h19;
    localparam logic [2:0] LOCK_COUNT_STD = 3'h3;
    localparam logic [2:0] LOCK_COUNT_PREC = 3'h5;
endpackage

// file: common/lock_if.sv
// Carries phase detector results to the lock detector and lock state back
`timescale 1ns/100ps
interface lock_if;
    logic cycle;
    logic [7:0] phase_err_ns;
    logic precision;
    logic enable;
    logic locked;
    modport port_side (output cycle, output phase_err_ns, output precision, output enable,
        input locked);
    modport detector (input cycle, input phase_err_ns, input precision, input enable,
        output locked);
endinterface

// file: hw/lock_detector.sv
// Digital lock detector counting consecutive good phase detector cycles
`timescale 1ns/100ps
module lock_detector
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Detector link
    lock_if.detector lk
);
    logic [2:0] good_count;
    logic [2:0] needed;
    logic locked;

    assign needed = lk.precision ? latch_port_pkg::LOCK_COUNT_PREC
                                 : latch_port_pkg::LOCK_COUNT_STD;
    assign lk.locked = locked;

    // Count clean cycles; any cycle above the loose limit drops lock
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            good_count <= 3'h0;
            locked <= 1'b0;
        end
        else if (!lk.enable)
        begin
            good_count <= 3'h0;
            locked <= 1'b0;
        end
        else if (lk.cycle)
        begin
            if (locked)
            begin
                if (lk.phase_err_ns > latch_port_pkg::UNLOCK_ERR_NS)
                begin
                    locked <= 1'b0;
                    good_count <= 3'h0;
                end
            end
            else if (lk.phase_err_ns < latch_port_pkg::LOCK_ERR_NS)
            begin
                good_count <= good_count + 3'h1;
                if (good_count + 3'h1 >= needed)
                begin
                    locked <= 1'b1;
                end
            end
            else
            begin
                good_count <= 3'h0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_lock_needs_count;
        !locked ##1 locked |-> $past(good_count) + 3'h1 >= $past(needed);
    endproperty
    a_lock_needs_count: assert property (p_lock_needs_count)
        else $error("lock set before enough clean cycles");

    property p_unlock_on_big_error;
        locked && lk.enable && lk.cycle
            && lk.phase_err_ns > latch_port_pkg::UNLOCK_ERR_NS |=> !locked;
    endproperty
    a_unlock_on_big_error: assert property (p_unlock_on_big_error)
        else $error("lock held after large phase error");

    property p_hold_on_mid_error;
        locked && lk.enable && lk.cycle
            && lk.phase_err_ns <= latch_port_pkg::UNLOCK_ERR_NS |=> locked;
    endproperty
    a_hold_on_mid_error: assert property (p_hold_on_mid_error)
        else $error("lock dropped on tolerable error");

    c_locks: cover property (!locked ##1 locked);
endmodule // lock_detector

// file: hw/serial_latch_load_port.sv
// Three-wire serial programming port with latch load, power and monitor logic
`timescale 1ns/100ps
module serial_latch_load_port
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Serial pins
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic word_load_strobe_in,
    input wire logic chip_enable_in,
    // Analog side status
    input wire logic pfd_cycle_in,
    input wire logic [7:0] phase_err_ns_in,
    input wire logic fb_div_in,
    input wire logic ref_div_in,
    // Latches
    output logic [23:0] control_latch_out,
    output logic [23:0] ref_div_latch_out,
    output logic [23:0] fb_div_latch_out,
    output logic [23:0] test_latch_out,
    // Power and monitor
    output logic powered_up_out,
    output logic pump_output_en_out,
    output logic lock_detect_out,
    output logic monitor_output_out
);
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic sclk_prev;
    logic load_prev;
    logic sclk_rise;
    logic load_rise;
    logic [23:0] shift;

    // Two flops per pin; pins are asynchronous to clk_in
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end
        else
        begin
            sync_a <= {chip_enable_in, word_load_strobe_in, serial_data_in, serial_clock_in};
            sync_b <= sync_a;
        end
    end

    // Edge history, fed only from the second stage
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sclk_prev <= 1'b0;
            load_prev <= 1'b0;
        end
        else
        begin
            sclk_prev <= sync_b[0];
            load_prev <= sync_b[2];
        end
    end

    assign sclk_rise = sync_b[0] && !sclk_prev;
    assign load_rise = sync_b[2] && !load_prev;

    // ---------------------------------------------------------------
    // Shift register and latches
    // ---------------------------------------------------------------
    // MSB first: newest bit enters at bit 0, so the select lands in bits 1:0
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            shift <= latch_port_pkg::LATCH_RESET;
        end
        else if (sclk_rise)
        begin
            shift <= {shift[22:0], sync_b[1]};
        end
    end

    // Only a load edge writes; shifting never disturbs the latches
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            control_latch_out <= latch_port_pkg::LATCH_RESET;
            ref_div_latch_out <= latch_port_pkg::LATCH_RESET;
            fb_div_latch_out <= latch_port_pkg::LATCH_RESET;
            test_latch_out <= latch_port_pkg::LATCH_RESET;
        end
        else if (load_rise)
        begin
            unique case (shift[1:0])
                latch_port_pkg::SEL_CONTROL: control_latch_out <= shift;
                latch_port_pkg::SEL_REF_DIV: ref_div_latch_out <= shift;
                latch_port_pkg::SEL_FB_DIV: fb_div_latch_out <= shift;
                latch_port_pkg::SEL_TEST: test_latch_out <= shift; // Factory use only
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Power control
    // ---------------------------------------------------------------
    logic next_powered;
    assign next_powered = sync_b[3] && !control_latch_out[latch_port_pkg::PD1_BIT]
                          && !control_latch_out[latch_port_pkg::PD2_BIT];

    // Pump three-states whenever the part is down or software asks for it
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            powered_up_out <= 1'b0;
            pump_output_en_out <= 1'b0;
        end
        else
        begin
            powered_up_out <= next_powered;
            pump_output_en_out <= next_powered
                && !control_latch_out[latch_port_pkg::PUMP_TRI_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Lock detect and monitor
    // ---------------------------------------------------------------
    lock_if lk ();
    assign lk.cycle = pfd_cycle_in;
    assign lk.phase_err_ns = phase_err_ns_in;
    assign lk.precision = ref_div_latch_out[latch_port_pkg::LOCK_PRECISION_BIT];
    assign lk.enable = next_powered;

    lock_detector u_lock
    (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .lk(lk)
    );

    logic [2:0] mon_sel;
    logic next_monitor;
    assign mon_sel = control_latch_out[latch_port_pkg::MON_LSB +: latch_port_pkg::MON_W];

    // Unlisted codes drive low rather than float
    always_comb
    begin
        case (mon_sel)
            latch_port_pkg::MON_LOCK: next_monitor = lk.locked;
            latch_port_pkg::MON_FB_DIV: next_monitor = fb_div_in;
            latch_port_pkg::MON_REF_DIV: next_monitor = ref_div_in;
            default: next_monitor = 1'b0;
        endcase
    end

    // Registered for a glitch-free pin, at one cycle of latency
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            monitor_output_out <= 1'b0;
            lock_detect_out <= 1'b0;
        end
        else
        begin
            monitor_output_out <= next_monitor;
            lock_detect_out <= lk.locked;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_shift_in;
        sclk_rise |=> shift == {$past(shift[22:0]), $past(sync_b[1])};
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("shift register missed a serial bit");

    property p_load_ctrl;
        load_rise && shift[1:0] == 2'h0 |=> control_latch_out == $past(shift);
    endproperty
    a_load_ctrl: assert property (p_load_ctrl)
        else $error("control latch not loaded");

    property p_load_fb;
        load_rise && shift[1:0] == 2'h2 |=> fb_div_latch_out == $past(shift)
            && $stable(control_latch_out) && $stable(ref_div_latch_out);
    endproperty
    a_load_fb: assert property (p_load_fb)
        else $error("feedback latch load wrong or touched another latch");

    property p_latch_stable;
        !load_rise |=> $stable(control_latch_out) && $stable(test_latch_out)
            && $stable(ref_div_latch_out) && $stable(fb_div_latch_out);
    endproperty
    a_latch_stable: assert property (p_latch_stable)
        else $error("latch changed without a load edge");

    property p_ce_low_down;
        !sync_b[3] |=> !powered_up_out && !pump_output_en_out;
    endproperty
    a_ce_low_down: assert property (p_ce_low_down)
        else $error("powered while chip enable low");

    property p_pd_bits;
        sync_b[3] ##1 powered_up_out
            |-> !$past(control_latch_out[latch_port_pkg::PD1_BIT])
            && !$past(control_latch_out[latch_port_pkg::PD2_BIT]);
    endproperty
    a_pd_bits: assert property (p_pd_bits)
        else $error("powered despite power-down bits");

    property p_monitor_lock;
        mon_sel == latch_port_pkg::MON_LOCK |=> monitor_output_out == $past(lk.locked);
    endproperty
    a_monitor_lock: assert property (p_monitor_lock)
        else $error("monitor not following lock detect");

    property p_lock_out;
        lk.locked |=> lock_detect_out;
    endproperty
    a_lock_out: assert property (p_lock_out)
        else $error("lock detect output lagging");

    c_load_test: cover property (load_rise && shift[1:0] == 2'h3);
    c_power_up: cover property (!powered_up_out ##1 powered_up_out);
    c_mon_ref: cover property (mon_sel == 3'h4 && ref_div_in);
endmodule // serial_latch_load_port

// file: dv/serial_controller_model.sv
// Behavioural model of the controller driving the three-wire programming port
`timescale 1ns/100ps
module serial_controller_model
(
    // Clock
    input wire logic clk_in,
    // Serial pins
    output logic serial_clock_out,
    output logic serial_data_out,
    output logic word_load_strobe_out
);
    // Idle pins; serial clock stands still outside frames
    initial
    begin
        serial_clock_out = 1'b0;
        serial_data_out = 1'b0;
        word_load_strobe_out = 1'b0;
    end

    // Shift a word, MSB first, so the last two bits are the select
    // Three clk periods high and four low per bit, above the 80 ns the port needs
    task automatic shift_bits(input logic [23:0] word);
        for (int i = 23; i >= 0; i--)
        begin
            @(posedge clk_in) serial_data_out <= word[i];
            repeat (3) @(posedge clk_in);
            serial_clock_out <= 1'b1;
            repeat (3) @(posedge clk_in);
            serial_clock_out <= 1'b0;
        end
    endtask

    // Load pulse with the clock still; data line then shows no stale value
    // Test latch words come only from the bench's own explicit request
    task automatic pulse_load();
        repeat (3) @(posedge clk_in);
        word_load_strobe_out <= 1'b1;
        repeat (3) @(posedge clk_in);
        word_load_strobe_out <= 1'b0;
        serial_data_out <= ~serial_data_out;
        repeat (3) @(posedge clk_in);
    endtask
endmodule // serial_controller_model

// file: dv/serial_latch_load_port_tb.sv
// Self-checking bench for the serial latch load port
`timescale 1ns/100ps
module serial_latch_load_port_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b0;
    logic pfd = 1'b0;
    logic [7:0] err_ns = 8'h00;
    logic fbd = 1'b0;
    logic refd = 1'b0;
    logic sck, sda, load_pin;
    logic [23:0] l_ctrl, l_ref, l_fb, l_test;
    logic [23:0] seen [4];
    logic [23:0] exp_l [4];
    logic powered, pump_en, lock, mon;
    int err_count = 0;
    int num_checks = 0;

    serial_controller_model ctl (.clk_in(clk), .serial_clock_out(sck),
        .serial_data_out(sda), .word_load_strobe_out(load_pin));

    serial_latch_load_port DUT (.clk_in(clk), .rst_b_in(rst_b), .serial_clock_in(sck),
        .serial_data_in(sda), .word_load_strobe_in(load_pin), .chip_enable_in(ce),
        .pfd_cycle_in(pfd), .phase_err_ns_in(err_ns), .fb_div_in(fbd), .ref_div_in(refd),
        .control_latch_out(l_ctrl), .ref_div_latch_out(l_ref),
        .fb_div_latch_out(l_fb), .test_latch_out(l_test),
        .powered_up_out(powered), .pump_output_en_out(pump_en),
        .lock_detect_out(lock), .monitor_output_out(mon));

    // Latches gathered by select code for indexed compares
    always_comb
    begin
        seen[0] = l_ctrl;
        seen[1] = l_ref;
        seen[2] = l_fb;
        seen[3] = l_test;
    end

    // 25 MHz clock
    initial
    begin
        forever #20 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Shift, prove latches untouched, then load and compare all four
    task automatic load_word(input logic [23:0] w);
        ctl.shift_bits(w);
        for (int k = 0; k < 4; k++)
            check("latch while shifting", exp_l[k], seen[k]);
        ctl.pulse_load();
        exp_l[w[1:0]] = w;
        for (int k = 0; k < 4; k++)
            check("latch after load", exp_l[k], seen[k]);
    endtask

    // One detector cycle with the given phase error
    task automatic pd_cycle(input logic [7:0] e);
        @(posedge clk) pfd <= 1'b1;
        err_ns <= e;
        @(posedge clk) pfd <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    // Every select code once, each word distinct in its upper bits
    task automatic sc_select();
        for (int s = 0; s < 4; s++)
            load_word({22'(22'h29D0F3 ^ (22'h1111 * s)), s[1:0]});
    endtask

    // Chip enable low, then power-down bits, then pump three-state bit
    task automatic sc_power();
        load_word(24'h000000);
        check("powered with ce low", 24'h0, {23'h0, powered});
        check("pump with ce low", 24'h0, {23'h0, pump_en});
        load_word(24'h100000);
        @(posedge clk) ce <= 1'b1;
        repeat (5) @(posedge clk);
        check("powered with pd1", 24'h0, {23'h0, powered});
        load_word(24'h200000);
        check("powered with pd2", 24'h0, {23'h0, powered});
        load_word(24'h000800);
        check("powered", 24'h1, {23'h0, powered});
        check("pump three-state bit", 24'h0, {23'h0, pump_en});
        load_word(24'h000000);
        check("pump enabled", 24'h1, {23'h0, pump_en});
        check("monitor code 0 low", 24'h0, {23'h0, mon});
    endtask

    // Count restart on 15 ns, set after three, hold at 25 ns, clear above
    task automatic sc_lock();
        load_word(24'h000001);
        repeat (2) pd_cycle(8'h0E);
        pd_cycle(8'h0F);
        repeat (2) pd_cycle(8'h0E);
        check("lock after two", 24'h0, {23'h0, lock});
        pd_cycle(8'h0E);
        check("lock after three", 24'h1, {23'h0, lock});
        pd_cycle(8'h19);
        check("lock at 25 ns", 24'h1, {23'h0, lock});
        pd_cycle(8'h1A);
        check("lock above 25 ns", 24'h0, {23'h0, lock});
        load_word(24'h040001);
        repeat (4) pd_cycle(8'h00);
        check("precision after four", 24'h0, {23'h0, lock});
        pd_cycle(8'h00);
        check("precision after five", 24'h1, {23'h0, lock});
    endtask

    // Monitor sources: lock, divided output, divided reference
    task automatic sc_monitor();
        load_word(24'h000020);
        check("monitor lock", 24'h1, {23'h0, mon});
        load_word(24'h000040);
        @(posedge clk) fbd <= 1'b1;
        repeat (3) @(posedge clk);
        check("monitor fb high", 24'h1, {23'h0, mon});
        @(posedge clk) fbd <= 1'b0;
        repeat (3) @(posedge clk);
        check("monitor fb low", 24'h0, {23'h0, mon});
        load_word(24'h000080);
        @(posedge clk) refd <= 1'b1;
        repeat (3) @(posedge clk);
        check("monitor ref high", 24'h1, {23'h0, mon});
    endtask

    // Hang guard
    initial
    begin
        repeat (90000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        for (int k = 0; k < 4; k++)
            exp_l[k] = 24'h000000;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        for (int k = 0; k < 4; k++)
            check("latch reset", 24'h000000, seen[k]);
        sc_select();
        sc_power();
        sc_lock();
        sc_monitor();
        tally_and_finish();
    end
endmodule // serial_latch_load_port_tb
